// ### shared/exec_defs.svh
/*
  Constants of the instruction execution block: widths, field positions,
  reset values and timing counts.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH

// Widths
`define EXEC_DATA_W 8
`define EXEC_FADDR_W 7
`define EXEC_FILE_DEPTH 128
`define EXEC_K_W 11
`define EXEC_PC_W 13
`define EXEC_WDOG_W 8
`define EXEC_PRESC_W 8

// Program counter high latch fields feeding pc bits 12:11
`define EXEC_LATCH_HI_BIT 4
`define EXEC_LATCH_LO_BIT 3

// Reset values
`define EXEC_PC_RST 13'h0000
`define EXEC_ACC_RST 8'h00
`define EXEC_WDOG_CLR 8'h00
`define EXEC_PRESC_CLR 8'h00
`define EXEC_FLAG_RST 1'b1

// Timing: one instruction cycle lasts this many mclk periods
`define EXEC_MCLK_NS 100
`define EXEC_INSTR_CYCLE_NS 400
`define EXEC_INSTR_CYCLE_CLKS (`EXEC_INSTR_CYCLE_NS / `EXEC_MCLK_NS)

`endif

// ### shared/exec_pkg.sv
/*
  Types of the instruction execution block: operation codes, the
  instruction carrier and the sequencer states.
  Assumes exec_defs.svh on the include path.
*/
`include "exec_defs.svh"

package exec_pkg;

  // Operations handled by this block
  typedef enum logic [2:0] {
    nop_op = 3'h0,
    kick_watchdog_op = 3'h1,
    call_op = 3'h2,
    invert_file_op = 3'h3,
    zero_file_op = 3'h4,
    decrement_file_op = 3'h5,
    zero_accumulator_op = 3'h6,
    decrement_skip_if_null_op = 3'h7
  } op_type;

  // One decoded instruction as handed over by fetch
  typedef struct packed {
    op_type op;
    logic [`EXEC_FADDR_W-1:0] faddr;
    logic dest_file;
    logic [`EXEC_K_W-1:0] k;
  } instr_type;

  // Sequencer, Gray coded along idle, read, execute, second cycle
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_read = 2'b01,
    st_exec = 2'b11,
    st_second = 2'b10
  } seq_type;

endpackage

// ### core/file_mem.sv
/*
  Data register file: single write port, one read port whose data
  come out of a register one clock after the read strobe.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps

module file_mem #(
  parameter int DATA_W = 8,
  parameter int DEPTH = 128,
  parameter int ADDR_W = 7
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic rd_en,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data,
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data
);

  logic [DATA_W-1:0] mem_r [DEPTH];

  // Storage write
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  // Registered read
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem_r[rd_addr];
    end
  end

endmodule

// ### core/instr_exec.sv
/*
  Execution unit for the watchdog kick, call, invert, clear, decrement
  and decrement-skip instructions of an 8-bit core.
  Assumes a fetch stage on the same clock that offers one decoded
  instruction per instruction cycle and holds it while ready is low.
*/
// Notes on behaviour
// - Watchdog kick zeroes the watchdog counter.
// - Watchdog kick also zeroes the watchdog prescaler at once.
// - Watchdog kick sets expiry and sleep flags; no other status bit.
// - Call pushes current pc plus one onto the stack head first.
// - Call loads its eleven-bit operand into pc bits 10 to 0.
// - Call loads pc bits 12 and 11 from latch bits 4 and 3.
// - Call takes two instruction cycles and leaves status flags alone.
// - Invert complements the file; d picks accumulator or file.
// - Zero-file writes zero to the addressed file and sets zero flag.
// - Zero-accumulator clears the accumulator and sets the zero flag.
// - Decrement subtracts one; d picks accumulator or file.
// - Decrement-skip subtracts one, d picks destination, flags untouched.
// - Zero decrement-skip result discards next instruction, two cycles.
// - Nonzero decrement-skip result runs the next instruction normally.
`timescale 1ns/1ps
`include "exec_defs.svh"

module instr_exec #(
  parameter int CYCLE_CLKS = `EXEC_INSTR_CYCLE_CLKS
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic instr_valid,
  input exec_pkg::instr_type instr,
  input wire logic [`EXEC_DATA_W-1:0] program_counter_high_latch,
  input wire logic wdog_step,
  output logic instr_ready,
  output logic cycle_tick,
  output logic [`EXEC_PC_W-1:0] pc,
  output logic [`EXEC_PC_W-1:0] stack_head,
  output logic stack_push,
  output logic discard_next,
  output logic [`EXEC_DATA_W-1:0] accumulator,
  output logic zero_flag,
  output logic [`EXEC_WDOG_W-1:0] watchdog_counter,
  output logic [`EXEC_PRESC_W-1:0] watchdog_prescaler,
  output logic watchdog_expiry_flag,
  output logic sleep_entered_flag
);

  localparam int CNT_W = $clog2(CYCLE_CLKS + 1);

  exec_pkg::seq_type state_r;
  exec_pkg::instr_type cur_r;
  logic [CNT_W-1:0] div_r;
  logic [`EXEC_DATA_W-1:0] file_rd;
  logic [`EXEC_DATA_W-1:0] result;
  logic result_zero;
  logic accept;
  logic file_op;
  logic wr_en;

  // Instruction cycle divider
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      div_r <= '0;
      cycle_tick <= 1'b0;
    end else if (div_r == CNT_W'(CYCLE_CLKS - 1)) begin
      div_r <= '0;
      cycle_tick <= 1'b1;
    end else begin
      div_r <= div_r + CNT_W'(1);
      cycle_tick <= 1'b0;
    end
  end

  // One instruction taken per instruction cycle
  assign accept = cycle_tick && instr_valid && instr_ready;

  // Operations that read the addressed file
  always_comb begin
    file_op = (cur_r.op == exec_pkg::invert_file_op) ||
              (cur_r.op == exec_pkg::decrement_file_op) ||
              (cur_r.op == exec_pkg::decrement_skip_if_null_op);
  end

  // Result path
  always_comb begin
    case (cur_r.op)
      exec_pkg::invert_file_op: result = ~file_rd;
      exec_pkg::decrement_file_op: result = file_rd - `EXEC_DATA_W'(1);
      exec_pkg::decrement_skip_if_null_op: result = file_rd - `EXEC_DATA_W'(1);
      default: result = '0;
    endcase
    result_zero = (result == '0);
  end

  // File write: zero-file always, others when d selects the file
  always_comb begin
    wr_en = (state_r == exec_pkg::st_exec) &&
            ((cur_r.op == exec_pkg::zero_file_op) || (file_op && cur_r.dest_file));
  end

  file_mem #(
    .DATA_W(`EXEC_DATA_W),
    .DEPTH(`EXEC_FILE_DEPTH),
    .ADDR_W(`EXEC_FADDR_W)
  ) u_file (
    .mclk(mclk),
    .resetn(resetn),
    .rd_en(accept),
    .rd_addr(instr.faddr),
    .rd_data(file_rd),
    .wr_en(wr_en),
    .wr_addr(cur_r.faddr),
    .wr_data(result)
  );

  // Sequencer: read, execute, optional second instruction cycle
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_r <= exec_pkg::st_idle;
      cur_r <= '0;
      instr_ready <= 1'b1;
    end else begin
      case (state_r)
        exec_pkg::st_idle: begin
          if (accept) begin
            cur_r <= instr;
            state_r <= exec_pkg::st_read;
          end
        end
        exec_pkg::st_read: begin
          state_r <= exec_pkg::st_exec;
        end
        exec_pkg::st_exec: begin
          if (cur_r.op == exec_pkg::call_op) begin
            state_r <= exec_pkg::st_second;
            instr_ready <= 1'b0;
          // zero result costs a NOP cycle
          end else if (cur_r.op == exec_pkg::decrement_skip_if_null_op && result_zero) begin
            state_r <= exec_pkg::st_second;
            instr_ready <= 1'b0;
          end else begin
            state_r <= exec_pkg::st_idle;
          end
        end
        exec_pkg::st_second: begin
          if (cycle_tick) begin
            state_r <= exec_pkg::st_idle;
            instr_ready <= 1'b1;
          end
        end
        default: begin
          state_r <= exec_pkg::st_idle;
          instr_ready <= 1'b1;
        end
      endcase
    end
  end

  // Program counter and stack head
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pc <= `EXEC_PC_RST;
      stack_head <= `EXEC_PC_RST;
      stack_push <= 1'b0;
    end else begin
      stack_push <= 1'b0;
      if (state_r == exec_pkg::st_exec) begin
        if (cur_r.op == exec_pkg::call_op) begin
          stack_head <= pc + `EXEC_PC_W'(1);
          stack_push <= 1'b1;
          pc <= {program_counter_high_latch[`EXEC_LATCH_HI_BIT],
                 program_counter_high_latch[`EXEC_LATCH_LO_BIT], cur_r.k};
        end else if (cur_r.op == exec_pkg::decrement_skip_if_null_op && result_zero) begin
          pc <= pc + `EXEC_PC_W'(2);
        end else begin
          pc <= pc + `EXEC_PC_W'(1);
        end
      end
    end
  end

  // Skip indication to fetch, one pulse at execute
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      discard_next <= 1'b0;
    end else begin
      discard_next <= (state_r == exec_pkg::st_exec) &&
                      (cur_r.op == exec_pkg::decrement_skip_if_null_op) && result_zero;
    end
  end

  // Accumulator and zero flag
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      accumulator <= `EXEC_ACC_RST;
      zero_flag <= 1'b0;
    end else if (state_r == exec_pkg::st_exec) begin
      case (cur_r.op)
        exec_pkg::invert_file_op, exec_pkg::decrement_file_op: begin
          if (!cur_r.dest_file) begin
            accumulator <= result;
          end
          zero_flag <= result_zero;
        end
        exec_pkg::decrement_skip_if_null_op: begin
          if (!cur_r.dest_file) begin
            accumulator <= result;
          end
        end
        exec_pkg::zero_file_op: begin
          zero_flag <= 1'b1;
        end
        exec_pkg::zero_accumulator_op: begin
          accumulator <= `EXEC_ACC_RST;
          zero_flag <= 1'b1;
        end
        default: begin
          accumulator <= accumulator;
        end
      endcase
    end
  end

  // Watchdog counter and prescaler; kick wins over a step
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      watchdog_counter <= `EXEC_WDOG_CLR;
      watchdog_prescaler <= `EXEC_PRESC_CLR;
    end else if (state_r == exec_pkg::st_exec && cur_r.op == exec_pkg::kick_watchdog_op) begin
      watchdog_counter <= `EXEC_WDOG_CLR;
      watchdog_prescaler <= `EXEC_PRESC_CLR;
    end else if (wdog_step) begin
      watchdog_prescaler <= watchdog_prescaler + `EXEC_PRESC_W'(1);
      if (&watchdog_prescaler) begin
        watchdog_counter <= watchdog_counter + `EXEC_WDOG_W'(1);
      end
    end
  end

  // Status flags touched by the kick; counter expiry clears expiry flag
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      watchdog_expiry_flag <= `EXEC_FLAG_RST;
      sleep_entered_flag <= `EXEC_FLAG_RST;
    end else if (state_r == exec_pkg::st_exec && cur_r.op == exec_pkg::kick_watchdog_op) begin
      watchdog_expiry_flag <= 1'b1;
      sleep_entered_flag <= 1'b1;
    end else if (wdog_step && (&watchdog_prescaler) && (&watchdog_counter)) begin
      watchdog_expiry_flag <= 1'b0;
    end
  end

endmodule

// ### verif/instr_exec_checker.sv
/*
  Checker for the execution unit, seeing only its ports.
  Assumes four clocks per instruction cycle and results two edges after a take.
*/
`timescale 1ns/1ps
module instr_exec_checker #(
  parameter int CYCLE_CLKS = 4
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic instr_valid,
  input wire exec_pkg::instr_type instr,
  input wire logic [7:0] program_counter_high_latch,
  input wire logic wdog_step,
  input wire logic instr_ready,
  input wire logic cycle_tick,
  input wire logic [12:0] pc,
  input wire logic [12:0] stack_head,
  input wire logic stack_push,
  input wire logic discard_next,
  input wire logic [7:0] accumulator,
  input wire logic zero_flag,
  input wire logic [7:0] watchdog_counter,
  input wire logic [7:0] watchdog_prescaler,
  input wire logic watchdog_expiry_flag,
  input wire logic sleep_entered_flag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Taken operations by kind
  wire take = cycle_tick && instr_valid && instr_ready;
  wire t_kick = take && instr.op == exec_pkg::kick_watchdog_op;
  wire t_call = take && instr.op == exec_pkg::call_op;
  wire t_skip = take && instr.op == exec_pkg::decrement_skip_if_null_op;
  wire t_zacc = take && instr.op == exec_pkg::zero_accumulator_op;
  wire t_one = take && (instr.op inside {exec_pkg::invert_file_op, exec_pkg::zero_file_op,
    exec_pkg::decrement_file_op, exec_pkg::zero_accumulator_op});
  // Empty instruction cycle after a two-cycle operation
  sequence nop_slot;
    !instr_ready ##1 (cycle_tick && !instr_ready);
  endsequence
  AST_KICK_CLR: assert property (t_kick |-> ##3 watchdog_counter == 8'h00
    && watchdog_prescaler == 8'h00) else $error("watchdog not cleared");
  AST_KICK_FLAGS: assert property (t_kick |-> ##3 watchdog_expiry_flag
    && sleep_entered_flag && $stable(zero_flag)) else $error("kick flags");
  AST_CALL_PUSH: assert property (t_call |-> ##3 stack_push
    && stack_head == $past(pc) + 13'h0001) else $error("return address");
  AST_CALL_PC: assert property (t_call |-> ##3 pc ==
    {$past(program_counter_high_latch[4:3]), $past(instr.k, 3)}) else $error("call target");
  AST_CALL_SLOT: assert property (t_call |-> ##3 $stable(zero_flag) ##0 nop_slot)
    else $error("call slot");
  AST_SKIP_PC: assert property (t_skip |-> ##3 pc == $past(pc) +
    (discard_next ? 13'h0002 : 13'h0001)) else $error("skip pc");
  AST_SKIP_FLAG: assert property (t_skip |-> ##3 $stable(zero_flag))
    else $error("skip flag");
  AST_SKIP_SLOT: assert property (discard_next |-> nop_slot) else $error("skip slot");
  AST_NO_SLOT: assert property (t_skip ##3 !discard_next |-> ##1 instr_ready)
    else $error("extra slot");
  AST_ZACC: assert property (t_zacc |-> ##3 accumulator == 8'h00 && zero_flag)
    else $error("clear accumulator");
  AST_ONE_CYCLE: assert property (t_one |-> ##4 cycle_tick && instr_ready)
    else $error("one cycle");
endmodule
bind instr_exec instr_exec_checker #(.CYCLE_CLKS(CYCLE_CLKS)) chk (.mclk, .resetn,
  .instr_valid, .instr, .program_counter_high_latch, .wdog_step, .instr_ready, .cycle_tick,
  .pc, .stack_head, .stack_push, .discard_next, .accumulator, .zero_flag, .watchdog_counter,
  .watchdog_prescaler, .watchdog_expiry_flag, .sleep_entered_flag);

// ### verif/fetch_model.sv
/*
  Fetch stage model: offers queued words, stalls at random, drops skipped words.
  Assumes the bench fills q before reset is released.
*/
`timescale 1ns/1ps
module fetch_model (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic cycle_tick,
  input wire logic instr_ready,
  input wire logic discard_next,
  output logic instr_valid = 1'b0,
  output exec_pkg::instr_type instr = '0
);
  exec_pkg::instr_type q[$];
  logic nv;
  wire take = cycle_tick && instr_valid && instr_ready;
  // Offer, hold until taken, inverted word when idle
  // skipped word dropped
  always @(posedge mclk) begin
    nv = instr_valid && !take && !discard_next;
    if ((take || discard_next) && q.size() > 0) void'(q.pop_front());
    nv = resetn && (nv || (q.size() > 0 && $urandom_range(3) != 0));
    instr_valid <= nv;
    instr <= nv ? q[0] : exec_pkg::instr_type'(~instr);
  end
endmodule

// ### verif/mcu_instr_exec_clear_call_dec_tb_top.sv
/*
  Bench for the execution unit: random and directed words, reference model.
  Assumes four clocks per instruction cycle.
*/
`timescale 1ns/1ps
module mcu_instr_exec_clear_call_dec_tb_top;
  logic mclk = 0, resetn = 0, wdog_step = 0, instr_valid, instr_ready, cycle_tick;
  logic stack_push, discard_next, zero_flag, watchdog_expiry_flag, sleep_entered_flag;
  logic [12:0] pc, stack_head, epc = 13'h0000, esh = 13'h0000;
  logic [7:0] latch = 8'h00, accumulator, watchdog_counter, watchdog_prescaler;
  logic [7:0] fm [128];
  logic [7:0] acc = 8'h00, r;
  logic [6:0] a, b;
  logic z = 1'b0, ed, ep;
  int n_fail = 0, n_checks = 0, takes = 0, skips = 0, pushed = 0;
  exec_pkg::instr_type instr, cur;

  always #50 mclk = ~mclk;
  // Time base mostly high, so the watchdog counter leaves zero before a kick
  always @(posedge mclk) wdog_step <= ($urandom_range(7) != 0);

  instr_exec #(.CYCLE_CLKS(4)) DUT (.mclk, .resetn, .instr_valid, .instr,
    .program_counter_high_latch(latch), .wdog_step, .instr_ready, .cycle_tick, .pc,
    .stack_head, .stack_push, .discard_next, .accumulator, .zero_flag, .watchdog_counter,
    .watchdog_prescaler, .watchdog_expiry_flag, .sleep_entered_flag);
  fetch_model fm_u (.mclk, .resetn, .cycle_tick, .instr_ready, .discard_next, .instr_valid,
    .instr);

  task cmp(input string n, input logic [12:0] e, input logic [12:0] s);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  task push(input exec_pkg::op_type o, input logic [6:0] f, input logic d, input logic [10:0] k);
    fm_u.q.push_back('{o, f, d, k});
    pushed++;
  endtask

  task stop_test;
    if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Reference model step for one taken word
  task put;
    if (cur.dest_file) fm[cur.faddr] = r;
    else acc = r;
    epc++;
  endtask

  // Watch takes, run the model, compare two edges later
  initial begin
    forever begin
      @(posedge mclk);
      if (cycle_tick && instr_valid && instr_ready) begin
        cur = instr;
        takes++;
        ed = 0;
        ep = 0;
        case (cur.op)
          exec_pkg::call_op: begin
            esh = epc + 13'h0001;
            ep = 1;
            epc = {latch[4:3], cur.k};
          end
          exec_pkg::invert_file_op: begin r = ~fm[cur.faddr]; put(); z = r == 0; end
          exec_pkg::decrement_file_op: begin r = fm[cur.faddr] - 1; put(); z = r == 0; end
          exec_pkg::zero_file_op: begin fm[cur.faddr] = 0; z = 1; epc++; end
          exec_pkg::zero_accumulator_op: begin acc = 0; z = 1; epc++; end
          exec_pkg::decrement_skip_if_null_op: begin
            r = fm[cur.faddr] - 1;
            put();
            if (r == 0) begin ed = 1; epc++; skips++; end
          end
          default: epc++;
        endcase
        repeat (2) @(posedge mclk);
        #1;
        cmp("accumulator", acc, accumulator);
        cmp("zero_flag", z, zero_flag);
        cmp("pc", epc, pc);
        cmp("discard_next", ed, discard_next);
        cmp("stack_push", ep, stack_push);
        cmp("stack_head", esh, stack_head);
        if (cur.op == exec_pkg::kick_watchdog_op) begin
          cmp("watchdog_counter", 0, watchdog_counter);
          cmp("watchdog_prescaler", 0, watchdog_prescaler);
          cmp("flags", 2'b11, {watchdog_expiry_flag, sleep_entered_flag});
        end
        @(posedge mclk);
        latch <= 8'($urandom);
      end
    end
  end

  // Directed words, then a random stream
  initial begin
    void'($urandom(46));
    a = 7'($urandom);
    b = a ^ 7'h01;
    push(exec_pkg::zero_file_op, a, 0, 0);
    push(exec_pkg::zero_file_op, b, 0, 0);
    push(exec_pkg::decrement_file_op, a, 1, 0);
    push(exec_pkg::decrement_file_op, a, 1, 0);
    push(exec_pkg::invert_file_op, a, 1, 0);
    push(exec_pkg::decrement_skip_if_null_op, a, 1, 0);
    push(exec_pkg::call_op, a, 0, 11'h555);
    push(exec_pkg::decrement_skip_if_null_op, a, 0, 0);
    push(exec_pkg::zero_accumulator_op, a, 0, 0);
    // Long kick-free run, so the kick below clears a nonzero counter
    for (int n = 0; n < 80; n++) push(exec_pkg::nop_op, a, 0, 0);
    push(exec_pkg::kick_watchdog_op, a, 0, 0);
    push(exec_pkg::call_op, b, 0, 11'h7ff);
    push(exec_pkg::decrement_file_op, b, 0, 0);
    for (int n = 0; n < 60; n++)
      push(exec_pkg::op_type'($urandom_range(7)), $urandom_range(1) ? a : b, 1'($urandom),
        11'($urandom));
    push(exec_pkg::nop_op, a, 0, 0);
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    for (int n = 0; n < 5000 && fm_u.q.size() > 0; n++) @(posedge mclk);
    repeat (12) @(posedge mclk);
    cmp("word count", 13'(pushed), 13'(takes + skips));
    stop_test();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    stop_test();
  end
endmodule
